// ---- rate_link_asserts.sv ----
`timescale 1ns/1ps

module rate_link_checker (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        MISO,
    input  wire logic        MISO_OE,
    input  wire logic [8:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        WR_VALID,
    input  wire logic [8:0]  WR_ADDR,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        WR_READY
);
    // ----------------------------------------------------------------
    // frame trackers
    // ----------------------------------------------------------------
    logic [3:0] hi_q, hi_d;
    logic [5:0] rise_q, rise_d;
    logic       first_q, first_d;
    logic       sclk_q;

    // raw pin edges are counted, so bounds below allow for the sync delay
    always_comb begin
        hi_d    = (!CS_N) ? 4'h0 : ((hi_q == 4'hF) ? hi_q : hi_q + 4'h1);
        rise_d  = CS_N ? 6'h00 : rise_q + {5'h00, SCLK & ~sclk_q};
        first_d = first_q & ~(CS_N & (rise_q != 6'h00));
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            hi_q    <= 4'hF;
            rise_q  <= 6'h00;
            first_q <= 1'b1;
        end else begin
            hi_q    <= hi_d;
            rise_q  <= rise_d;
            first_q <= first_d;
        end
        sclk_q <= SCLK;
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_select;
        $fell(CS_N);
    endsequence
    sequence s_deselect;
        $rose(CS_N);
    endsequence

    a_oe_on_select: assert property (s_select |-> ##[2:6] MISO_OE)
        else $error("output enable missing after select");
    a_oe_after_deselect: assert property (s_deselect |-> ##[1:6] !MISO_OE)
        else $error("output enable held after deselect");
    a_oe_needs_select: assert property (MISO_OE |-> hi_q < 4'h6)
        else $error("output enable while not selected");
    a_miso_quiet_off: assert property (!MISO_OE |-> !MISO)
        else $error("data driven while disabled");
    a_miso_steady_high: assert property ($rose(SCLK) |=> $stable(MISO) [*8])
        else $error("data changed while clock high");
    a_first_word_zero: assert property (first_q && rise_q < 6'h1F |-> !MISO)
        else $error("first response word wrong");
    a_reg_after_frame: assert property ($changed({REG_ADDR, REG_WR}) |-> CS_N)
        else $error("register port moved inside a frame");
    a_wr_after_frame: assert property ($rose(WR_VALID) |-> CS_N)
        else $error("write request raised inside a frame");
    a_wr_head_hold: assert property (WR_VALID && !WR_READY |=>
        WR_VALID && $stable({WR_ADDR, WR_DATA}))
        else $error("write head lost while stalled");
endmodule // rate_link_checker

bind rate_sensor_spi_link rate_link_checker chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
    .SCLK(SCLK), .CS_N(CS_N), .MISO(MISO), .MISO_OE(MISO_OE), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .WR_VALID(WR_VALID), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .WR_READY(WR_READY));

// ---- rate_link_pkg.sv ----
package rate_link_pkg;

    // ------------------------------------------------------------------
    // frame and fixed words
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS     = 32;
    localparam logic [5:0]  FRAME_BITS_CNT = 6'h20;
    localparam logic [5:0]  BITS_SAT       = 6'h3F;
    localparam logic [31:0] FIRST_RESPONSE = 32'h00000001;
    localparam logic [31:0] TX_RESET       = FIRST_RESPONSE;

    // ------------------------------------------------------------------
    // command and response codes
    // ------------------------------------------------------------------
    localparam int         SENSOR_FLAG_BIT = 29;
    localparam logic [2:0] OP_READ         = 3'h4;
    localparam logic [2:0] OP_WRITE        = 3'h2;
    localparam logic [2:0] RESP_READ       = 3'h2;
    localparam logic [2:0] RESP_WRITE      = 3'h1;
    localparam logic [2:0] RESP_ERROR      = 3'h0;
    localparam logic [3:0] RW_MARK         = 4'hE;
    localparam logic [2:0] MODULE_SEL_NONE = 3'h0;
    localparam logic [1:0] ST_ERROR        = 2'h0;
    localparam logic [1:0] ST_VALID        = 2'h1;
    localparam logic [1:0] ST_SELF_TEST    = 2'h2;
    localparam logic [1:0] ST_RW           = 2'h3;

    // ------------------------------------------------------------------
    // word layouts, most significant field first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  seq_low;
        logic        sensor_flag;
        logic        seq_high;
        logic [25:0] unused;
        logic        fault_check_request;
        logic        parity;
    } sensor_cmd_s;

    typedef struct packed {
        logic [2:0]  kind;
        logic [2:0]  sensor_module_select;
        logic [8:0]  register_address;
        logic [15:0] payload_word;
        logic        parity;
    } reg_cmd_s;

    typedef struct packed {
        logic [2:0]  sequence_tag;
        logic        upper_half_parity;
        logic [1:0]  status_code;
        logic [15:0] payload_word;
        logic [1:0]  gap;
        logic [6:0]  fault_flags;
        logic        full_response_parity;
    } sensor_resp_s;

    typedef struct packed {
        logic [2:0]  kind;
        logic        upper_half_parity;
        logic [3:0]  mark;
        logic [2:0]  sensor_module_select;
        logic [15:0] payload_word;
        logic [3:0]  gap;
        logic        full_response_parity;
    } rw_resp_s;

    typedef struct packed {
        logic [2:0]  kind;
        logic        upper_half_parity;
        logic [3:0]  mark;
        logic [2:0]  sensor_module_select;
        logic [1:0]  gap_high;
        logic        framing_error;
        logic        request_error;
        logic        data_unavailable;
        logic [7:0]  gap_low;
        logic [6:0]  fault_flags;
        logic        full_response_parity;
    } err_resp_s;

    typedef struct packed {
        logic [15:0] rate;
        logic [1:0]  status_code;
        logic [5:0]  faults;
    } snapshot_s;

    typedef struct packed {
        logic [8:0]  register_address;
        logic [15:0] payload_word;
    } wr_req_s;

endpackage

// ---- rate_sensor_spi_link.sv ----
`timescale 1ns/1ps

// Function
// - one 32-bit command and one 32-bit response per chip-select period.
// - clock idles low; data sampled on rising SCLK edge.
// - first response after startup is the fixed word 0x00000001.
// - snapshot of sensor data taken when chip select falls.
// - result loaded in S_BUILD, two clocks after chip-select rise is seen; sent during the next exchange.
// - response data is from previous chip-select fall; no refresh between.
// - three-bit sequence tag echoed unchanged in the sensor response.
// - module select is unused; host sends 000, device echoes 000.
// - sensor response: tag 31:29, parity 28, status 27:26, rate 25:10.
// - sensor and error responses carry seven fault flags 7:1, parity 0.
// - bit 28 makes response bits 31:16 odd parity.
// - bit 0 makes the whole response odd parity.
// - status 00 error, 01 valid, 10 self-test, 11 read/write.
module rate_sensor_spi_link (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        MOSI,
    output logic             MISO,
    output logic             MISO_OE,
    input  wire logic [15:0] RATE_DATA,
    input  wire logic [1:0]  SENSOR_STATUS,
    input  wire logic [5:0]  FAULT_FLAGS,
    output logic [8:0]       REG_ADDR,
    output logic             REG_WR,
    input  wire logic [15:0] REG_RDATA,
    input  wire logic        REG_ERR,
    output logic             WR_VALID,
    output logic [8:0]       WR_ADDR,
    output logic [15:0]      WR_DATA,
    input  wire logic        WR_READY
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] prev_q;
    logic       sclk_s;
    logic       cs_n_s;
    logic       mosi_s;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            prev_q <= 2'h1;
        end else begin
            meta_q <= {SCLK, CS_N, MOSI};
            sync_q <= meta_q;
            prev_q <= sync_q[2:1];
        end
    end

    assign sclk_s = sync_q[2];
    assign cs_n_s = sync_q[1];
    assign mosi_s = sync_q[0];

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_fall   = prev_q[0] & ~cs_n_s;
    assign cs_rise   = ~prev_q[0] & cs_n_s;
    assign sclk_rise = ~prev_q[1] & sclk_s & ~cs_n_s;
    assign sclk_fall = prev_q[1] & ~sclk_s & ~cs_n_s;

    // ------------------------------------------------------------------
    // exchange state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_FRAME, S_LOOKUP, S_BUILD} link_state_e;

    link_state_e               state_q;
    link_state_e               state_d;
    logic [31:0]               rx_q;
    logic [31:0]               rx_d;
    logic [31:0]               tx_q;
    logic [31:0]               tx_d;
    logic [5:0]                bits_q;
    logic [5:0]                bits_d;
    rate_link_pkg::snapshot_s  snap_q;
    rate_link_pkg::snapshot_s  snap_d;
    logic                      miso_q;
    logic                      miso_d;
    logic                      oe_q;
    logic                      oe_d;
    logic [8:0]                reg_addr_q;
    logic [8:0]                reg_addr_d;
    logic                      reg_wr_q;
    logic                      reg_wr_d;

    rate_link_pkg::reg_cmd_s    cmd;
    rate_link_pkg::sensor_cmd_s scmd;
    logic                       frame_ok;
    logic                       is_sensor;
    logic                       is_read;
    logic                       is_write;
    logic                       buf_ready;
    logic                       wr_push;
    logic [31:0]                resp;

    assign cmd       = rate_link_pkg::reg_cmd_s'(rx_q);
    assign scmd      = rate_link_pkg::sensor_cmd_s'(rx_q);
    // a short or long frame, or even parity, is a framing fault
    assign frame_ok  = (bits_q == rate_link_pkg::FRAME_BITS_CNT) && (^rx_q);
    assign is_sensor = rx_q[rate_link_pkg::SENSOR_FLAG_BIT];
    assign is_read   = cmd.kind == rate_link_pkg::OP_READ;
    assign is_write  = cmd.kind == rate_link_pkg::OP_WRITE;

    // ------------------------------------------------------------------
    // response assembly, valid in S_BUILD
    // ------------------------------------------------------------------
    always_comb begin
        rate_link_pkg::sensor_resp_s sr;
        rate_link_pkg::rw_resp_s     rr;
        rate_link_pkg::err_resp_s    er;
        logic [31:0]                 w;
        w  = '0;
        sr = '0;
        rr = '0;
        er = '0;
        wr_push = 1'b0;
        sr.sequence_tag = {scmd.seq_high, scmd.seq_low};
        sr.status_code  = snap_q.status_code;
        sr.payload_word = snap_q.rate;
        sr.fault_flags  = {snap_q.faults, scmd.fault_check_request};
        er.kind                 = rate_link_pkg::RESP_ERROR;
        er.mark                 = rate_link_pkg::RW_MARK;
        er.sensor_module_select = rate_link_pkg::MODULE_SEL_NONE;
        er.fault_flags          = {snap_q.faults, 1'b0};
        rr.mark                 = rate_link_pkg::RW_MARK;
        rr.sensor_module_select = rate_link_pkg::MODULE_SEL_NONE;
        if (!frame_ok) begin
            er.framing_error = 1'b1;
            w = er;
        end else if (is_sensor) begin
            w = sr;
        end else if (!(is_read || is_write) || REG_ERR) begin
            er.request_error = 1'b1;
            w = er;
        end else if (is_write && !buf_ready) begin
            // write store still busy: refuse rather than drop the word
            er.data_unavailable = 1'b1;
            w = er;
        end else if (is_write) begin
            rr.kind         = rate_link_pkg::RESP_WRITE;
            rr.payload_word = cmd.payload_word;
            wr_push         = (state_q == S_BUILD);
            w = rr;
        end else begin
            rr.kind         = rate_link_pkg::RESP_READ;
            rr.payload_word = REG_RDATA;
            w = rr;
        end
        w[28] = ~^{w[31:29], w[27:16]};
        w[0]  = ~^w[31:1];
        resp  = w;
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        bits_d     = bits_q;
        snap_d     = snap_q;
        miso_d     = miso_q;
        oe_d       = oe_q;
        reg_addr_d = reg_addr_q;
        reg_wr_d   = reg_wr_q;
        unique case (state_q)
            S_IDLE: begin
                if (cs_fall) begin
                    snap_d  = '{rate: RATE_DATA, status_code: SENSOR_STATUS,
                                faults: FAULT_FLAGS};
                    rx_d    = '0;
                    bits_d  = '0;
                    oe_d    = 1'b1;
                    miso_d  = tx_q[31];
                    state_d = S_FRAME;
                end
            end
            S_FRAME: begin
                if (cs_rise) begin
                    oe_d    = 1'b0;
                    miso_d  = 1'b0;
                    state_d = S_LOOKUP;
                end else begin
                    if (sclk_rise) begin
                        rx_d = {rx_q[30:0], mosi_s};
                        if (bits_q != rate_link_pkg::BITS_SAT) begin
                            bits_d = bits_q + 6'h01;
                        end
                    end
                    if (sclk_fall) begin
                        tx_d   = {tx_q[30:0], 1'b0};
                        miso_d = tx_q[30];
                    end
                end
            end
            S_LOOKUP: begin
                reg_addr_d = cmd.register_address;
                reg_wr_d   = is_write;
                state_d    = S_BUILD;
            end
            S_BUILD: begin
                tx_d    = resp;
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q    <= S_IDLE;
            rx_q       <= '0;
            tx_q       <= rate_link_pkg::TX_RESET;
            bits_q     <= '0;
            snap_q     <= '0;
            miso_q     <= 1'b0;
            oe_q       <= 1'b0;
            reg_addr_q <= '0;
            reg_wr_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            rx_q       <= rx_d;
            tx_q       <= tx_d;
            bits_q     <= bits_d;
            snap_q     <= snap_d;
            miso_q     <= miso_d;
            oe_q       <= oe_d;
            reg_addr_q <= reg_addr_d;
            reg_wr_q   <= reg_wr_d;
        end
    end

    // ------------------------------------------------------------------
    // write request buffer toward the register store
    // ------------------------------------------------------------------
    rate_link_pkg::wr_req_s wr_in;
    rate_link_pkg::wr_req_s wr_head;

    assign wr_in = '{register_address: cmd.register_address, payload_word: cmd.payload_word};

    stage_buffer #(
        .WIDTH ($bits(rate_link_pkg::wr_req_s)),
        .DEPTH (2)
    ) u_wr_buffer (
        .clk       (CORE_CLK),
        .rst       (RST),
        .in_valid  (wr_push),
        .in_data   (wr_in),
        .in_ready  (buf_ready),
        .out_valid (WR_VALID),
        .out_data  (wr_head),
        .out_ready (WR_READY)
    );

    assign WR_ADDR  = wr_head.register_address;
    assign WR_DATA  = wr_head.payload_word;
    assign MISO     = miso_q;
    assign MISO_OE  = oe_q;
    assign REG_ADDR = reg_addr_q;
    assign REG_WR   = reg_wr_q;

endmodule // rate_sensor_spi_link

// ---- spi_host_model.sv ----
`timescale 1ns/1ps

module spi_host_model #(
    parameter real HALF_NS = 32.0,
    parameter real GAP_NS  = 400.0
) (
    input  wire logic        go,
    input  wire logic [31:0] cmd,
    input  wire logic [5:0]  nbits,
    input  wire logic        miso_line,
    output logic             sclk,
    output logic             cs_n,
    output logic             mosi,
    output logic [31:0]      resp,
    output logic             done
);
    // ----------------------------------------------------------------
    // serial master, clock stands low between frames
    // ----------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        resp = 32'h00000000;
        done = 1'b1;
    end

    always @(posedge go) begin
        done = 1'b0;
        resp = 32'h00000000;
        #1.3;
        cs_n = 1'b0;
        for (int i = 0; i < int'(nbits); i++) begin
            mosi = cmd[31 - i];
            #(HALF_NS);
            sclk = 1'b1;
            resp = {resp[30:0], miso_line};
            #(HALF_NS);
            sclk = 1'b0;
        end
        #(HALF_NS);
        cs_n = 1'b1;
        mosi = ~mosi;
        // spacing shortened from the real minimum to keep the run short
        #(GAP_NS);
        done = 1'b1;
    end
endmodule // spi_host_model

// ---- stage_buffer.sv ----
`timescale 1ns/1ps

module stage_buffer #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);

    // ------------------------------------------------------------------
    // shifting entries: slot 0 is always the head, so outputs are flops
    // ------------------------------------------------------------------
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH-1:0] vld_d;
    logic [WIDTH-1:0] data_q [DEPTH];
    logic [WIDTH-1:0] data_d [DEPTH];

    always_comb begin
        logic pop;
        logic push;
        logic placed;
        pop    = vld_q[0] & out_ready;
        push   = in_valid & ~vld_q[DEPTH-1];
        placed = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                vld_d[i]  = (i < DEPTH - 1) ? vld_q[(i + 1) % DEPTH] : 1'b0;
                data_d[i] = data_q[(i + 1) % DEPTH];
            end else begin
                vld_d[i]  = vld_q[i];
                data_d[i] = data_q[i];
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !placed && !vld_d[i]) begin
                vld_d[i]  = 1'b1;
                data_d[i] = in_data;
                placed    = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vld_q <= '0;
        end else begin
            vld_q <= vld_d;
        end
        data_q <= data_d;
    end

    assign in_ready  = ~vld_q[DEPTH-1];
    assign out_valid = vld_q[0];
    assign out_data  = data_q[0];

endmodule // stage_buffer

// ---- test_rate_sensor_spi_link.sv ----
`timescale 1ns/1ps

module test_rate_sensor_spi_link;
    logic clk, rst, go, wr_ready, sclk, cs_n, mosi, done, miso, miso_oe, reg_wr, reg_err;
    logic wr_valid;
    logic [31:0] cmd, resp;
    logic [31:0] prev = 32'h00000001;
    logic [5:0]  nbits, faults;
    logic [15:0] rate, reg_rdata, wr_data;
    logic [1:0]  status;
    logic [8:0]  reg_addr, wr_addr;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    rate_link_pkg::wr_req_s heads [2] = '{'{9'h041, 16'h1357}, '{9'h042, 16'h2468}};

    // ----------------------------------------------------------------
    // environment
    // ----------------------------------------------------------------
    wire miso_line = miso_oe ? miso : 1'b1;
    assign reg_rdata = {reg_addr[7:0], ~reg_addr[7:0]};
    assign reg_err   = (reg_addr == 9'h1FF) | (reg_wr & reg_addr[8]);

    rate_sensor_spi_link dut_u (.CORE_CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .RATE_DATA(rate),
        .SENSOR_STATUS(status), .FAULT_FLAGS(faults), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_RDATA(reg_rdata), .REG_ERR(reg_err), .WR_VALID(wr_valid), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .WR_READY(wr_ready));
    spi_host_model host_u (.go(go), .cmd(cmd), .nbits(nbits), .miso_line(miso_line),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .resp(resp), .done(done));

    // ----------------------------------------------------------------
    // words and helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] seal(input logic [31:0] w);
        logic [31:0] r;
        r = w;
        r[28] = ~^r[31:16];
        r[0]  = ~^r[31:1];
        return r;
    endfunction
    function automatic logic [31:0] par(input logic [31:0] c);
        return {c[31:1], ~^c[31:1]};
    endfunction
    function automatic logic [31:0] sens_cmd(input logic [2:0] t, input logic k);
        return par({t[1:0], 1'b1, t[2], 26'h0, k, 1'b0});
    endfunction
    function automatic logic [31:0] rd_cmd(input logic [8:0] a);
        return par({6'h20, a, 17'h0});
    endfunction
    function automatic logic [31:0] wr_cmd(input logic [8:0] a, input logic [15:0] d);
        return par({6'h10, a, d, 1'b0});
    endfunction
    function automatic logic [31:0] sens_word(input logic [2:0] t, input logic k);
        return seal({t, 1'b0, status, rate, 2'h0, faults, k, 1'b0});
    endfunction
    function automatic logic [31:0] rw_word(input logic [2:0] k, input logic [15:0] d);
        return seal({k, 1'b0, 4'hE, 3'h0, d, 5'h00});
    endfunction
    function automatic logic [31:0] err_word(input logic [2:0] e);
        return seal({8'h0E, 3'h0, 2'h0, e, 8'h00, faults, 2'h0});
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input logic [31:0] c, input logic [5:0] n, input logic [31:0] nxt);
        int k;
        @(posedge clk);
        cmd   <= c;
        nbits <= n;
        go    <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        // a host that never finishes its frame counts as a mismatch
        if (done !== 1'b1) begin
            n_errors++;
        end
        check("response", resp, prev >> (6'h20 - n));
        prev = nxt;
    endtask
    task automatic set_in(input logic [15:0] r, input logic [1:0] s, input logic [5:0] f);
        @(posedge clk);
        rate   <= r;
        status <= s;
        faults <= f;
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_tags();
        for (int t = 0; t < 8; t++) begin
            set_in(16'hA5C3 + 16'(t), 2'(t % 3), 6'(1 << (t % 6)));
            frame(sens_cmd(3'(t), t[0]), 6'h20, sens_word(3'(t), t[0]));
        end
    endtask
    task automatic t_stale();
        set_in(16'h1111, 2'h1, 6'h00);
        fork
            frame(sens_cmd(3'h1, 1'b0), 6'h20, sens_word(3'h1, 1'b0));
            begin
                repeat (150) @(posedge clk);
                rate <= 16'h2222;
            end
        join
        frame(sens_cmd(3'h2, 1'b0), 6'h20, sens_word(3'h2, 1'b0));
    endtask
    task automatic t_regs();
        frame(rd_cmd(9'h012), 6'h20, rw_word(3'h2, 16'h12ED));
        frame(wr_cmd(9'h034, 16'hBEEF), 6'h20, rw_word(3'h1, 16'hBEEF));
        frame(rd_cmd(9'h1FF), 6'h20, err_word(3'h2));
        frame(par(32'hC0000000), 6'h20, err_word(3'h2));
    endtask
    task automatic t_framing();
        set_in(16'h0F0F, 2'h1, 6'h2A);
        frame(sens_cmd(3'h3, 1'b0) ^ 32'h1, 6'h20, err_word(3'h4));
        frame(sens_cmd(3'h4, 1'b0), 6'h1F, err_word(3'h4));
    endtask
    task automatic t_buffer();
        @(posedge clk);
        wr_ready <= 1'b0;
        frame(wr_cmd(9'h041, 16'h1357), 6'h20, rw_word(3'h1, 16'h1357));
        frame(wr_cmd(9'h042, 16'h2468), 6'h20, rw_word(3'h1, 16'h2468));
        frame(wr_cmd(9'h043, 16'h0F0F), 6'h20, err_word(3'h1));
        frame(rd_cmd(9'h001), 6'h20, rw_word(3'h2, 16'h01FE));
        for (int i = 0; i < 2; i++) begin
            check("write head", {6'h00, wr_valid, wr_addr, wr_data}, {7'h01, heads[i]});
            @(posedge clk);
            wr_ready <= 1'b1;
            @(posedge clk);
            wr_ready <= 1'b0;
            @(posedge clk);
        end
        check("write empty", {31'h0, wr_valid}, 32'h0);
        wr_ready <= 1'b1;
    endtask
    task automatic t_reset();
        // flush the read answer left by the buffer scenario before reset
        frame(sens_cmd(3'h0, 1'b0), 6'h20, 32'h00000001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("enable after reset", {31'h0, miso_oe}, 32'h0);
        prev = 32'h00000001;
        frame(sens_cmd(3'h6, 1'b1), 6'h20, sens_word(3'h6, 1'b1));
        frame(sens_cmd(3'h7, 1'b0), 6'h20, sens_word(3'h7, 1'b0));
        frame(rd_cmd(9'h003), 6'h20, rw_word(3'h2, 16'h03FC));
    endtask

    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        go = 1'b0;
        wr_ready = 1'b1;
        cmd = 32'h00000000;
        nbits = 6'h20;
        rate = 16'h4321;
        status = 2'h1;
        faults = 6'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        frame(sens_cmd(3'h5, 1'b0), 6'h20, sens_word(3'h5, 1'b0));
        t_tags();
        t_stale();
        t_regs();
        t_framing();
        t_buffer();
        t_reset();
        complete_run();
    end
endmodule // test_rate_sensor_spi_link
